//--- ssp_bench.sv
// self-checking bench: host and device joined over the link
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    error_cnt++; $display("mismatch %s exp %h got %h", n, e, s); end end
module ssp_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [23:0] w;
        logic [15:0] n;
        logic [9:0]  r;
        logic [7:0]  fc;
        logic [3:0]  su;
        logic [3:0]  mult;
    } ssp_row_type;
    ssp_row_type rows [6] = '{
        '{24'h9abcde, 16'h4460, 10'h051, 8'h50, 4'h3, 4'h3},
        '{24'h523f4a, 16'h4460, 10'h123, 8'h50, 4'h1, 4'h1},
        '{24'h2c0800, 16'h0200, 10'h123, 8'ha5, 4'h5, 4'h1},
        '{24'h1ffffc, 16'hffff, 10'h123, 8'ha5, 4'h5, 4'h1},
        '{24'h7ff400, 16'hffff, 10'h3ff, 8'ha5, 4'h3, 4'h3},
        '{24'h0448d0, 16'h1234, 10'h3ff, 8'h00, 4'hf, 4'h3}};
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
    logic        aux = 0, ref_c = 0, mce = 0, err, seen;
    logic        pready, slverr, carry, su_o, pwr_up, dsync;
    logic        fm_o, lo_o, cp_o;
    logic [2:0]  nf_o, acc_o;
    logic [21:0] tb_o;
    logic [3:0]  tick = 0, su, mult_o;
    logic [7:0]  paddr = 0, fc_o;
    logic [9:0]  r_o;
    logic [15:0] n_o;
    logic [21:0] cfg_o;
    logic [31:0] pwdata = 0, prdata, rd;
    int          error_cnt = 0, comparisons = 0, cnt, zeros = 0;
    ssp_link_if link ();
    ssp_host ssp_host_i (.sys_clk_i(clk), .rst_n_i(rst_n), .paddr_i(paddr),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr), .link(link));
    ssp_device ssp_device_i (.sys_clk_i(clk), .rst_n_i(rst_n), .link(link),
        .aux_power_on_i(aux), .ref_in_i(ref_c), .main_pd_up_i(1'b0),
        .main_pd_dn_i(1'b0), .aux_pd_up_i(1'b0), .aux_pd_dn_i(1'b0),
        .main_cycle_end_i(mce), .main_divide_ratio_o(n_o),
        .fraction_modulus_select_o(fm_o), .fraction_increment_o(nf_o),
        .fraction_acc_o(acc_o), .fraction_carry_o(carry),
        .ref_divide_ratio_o(r_o),
        .comp_dac_value_o(fc_o), .lock_output_mode_o(lo_o),
        .pump_ratio_select_o(cp_o), .pump_current_mult_o(mult_o),
        .speedup_o(su_o), .power_up_o(pwr_up), .divider_sync_o(dsync),
        .config_word_o(cfg_o), .test_bits_o(tb_o));
    ssp_props ssp_props_i (.sys_clk_i(clk), .rst_n_i(rst_n),
        .serial_clk(link.serial_clk), .latch_enable(link.latch_enable),
        .serial_data(link.serial_data), .hard_power_pin(link.hard_power_pin),
        .phase_settled(link.phase_settled));
    initial forever #2.5 clk = ~clk;
    // reference and divider boundaries share one free counter
    always @(posedge clk) begin
        tick <= tick + 4'h1;
        ref_c <= tick[3];
        mce <= (tick[2:0] == 3'h7);
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = slverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // pump multiple is sampled mid-latch, where speed-up shows
    task automatic send(input logic [23:0] w, output logic [3:0] s);
        apb(1'b1, 8'h00, {8'h00, w});
        wait (link.latch_enable === 1'b1);
        repeat (10) @(posedge clk);
        s = mult_o;
        do apb(1'b0, 8'h08, 32'h0); while (rd[0] !== 1'b0);
    endtask : send
    task automatic summarize();
        $display("checks %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("reset ratio", 16'h4460, n_o)
        `CHK("reset power", 1'b0, pwr_up)
        foreach (rows[i]) begin
            send(rows[i].w, su);
            repeat (20) @(posedge clk);
            `CHK("ratio", rows[i].n, n_o)
            `CHK("ref ratio", rows[i].r, r_o)
            `CHK("dac", rows[i].fc, fc_o)
            `CHK("speedup mult", rows[i].su, su)
            `CHK("mult", rows[i].mult, mult_o)
            `CHK("pump sel", rows[i].mult == 4'h1, cp_o)
        end
        `CHK("config", 22'h1abcde, cfg_o)
        `CHK("fmod", 1'b0, fm_o)
        `CHK("incr", 3'h1, nf_o)
        `CHK("lock mode", 1'b0, lo_o)
        cnt = 0;
        repeat (128) begin
            @(posedge clk);
            cnt += int'(carry === 1'b1);
            zeros += int'(acc_o === 3'h0);
        end
        `CHK("carries", 2, cnt)
        `CHK("acc zeros", 16, zeros)
        aux <= 1'b1;
        repeat (100) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("settled both", 1'b1, rd[1])
        aux <= 1'b0;
        repeat (100) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("settled main", 1'b1, rd[1])
        apb(1'b1, 8'h04, 32'h1);
        repeat (100) @(posedge clk);
        `CHK("pin xor bit", 1'b0, pwr_up)
        `CHK("settled none", 1'b0, link.phase_settled)
        apb(1'b1, 8'h04, 32'h0);
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk);
            seen |= (dsync === 1'b1);
        end
        `CHK("resync", 1'b1, seen)
        send(24'hc04000, su);
        `CHK("forced speedup", 1'b1, su_o)
        `CHK("test bits", 22'h004000, tb_o)
        send(24'hc00000, su);
        `CHK("speedup off", 1'b0, su_o)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("unmapped", 1'b1, err)
        // second reset in mid-run must bring back the defaults
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK("rerun ratio", 16'h4460, n_o)
        `CHK("rerun dac", 8'h50, fc_o)
        `CHK("rerun power", 1'b0, pwr_up)
        summarize();
    end
    initial begin
        #100us;
        error_cnt++;
        summarize();
    end
endmodule : ssp_bench

//--- ssp_device.sv
// synthesizer side: serial word capture, registers, lock and power
//
// Our own choices: the APB register port and the register addresses.
module ssp_device
    import ssp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    ssp_link_if.device       link,
    input  wire logic        aux_power_on_i,
    input  wire logic        ref_in_i,
    input  wire logic        main_pd_up_i,
    input  wire logic        main_pd_dn_i,
    input  wire logic        aux_pd_up_i,
    input  wire logic        aux_pd_dn_i,
    input  wire logic        main_cycle_end_i,
    output logic [15:0]      main_divide_ratio_o,
    output logic             fraction_modulus_select_o,
    output logic [2:0]       fraction_increment_o,
    output logic [2:0]       fraction_acc_o,
    output logic             fraction_carry_o,
    output logic [9:0]       ref_divide_ratio_o,
    output logic [7:0]       comp_dac_value_o,
    output logic             lock_output_mode_o,
    output logic             pump_ratio_select_o,
    output logic [3:0]       pump_current_mult_o,
    output logic             speedup_o,
    output logic             power_up_o,
    output logic             divider_sync_o,
    output logic [21:0]      config_word_o,
    output logic [21:0]      test_bits_o
);
    localparam int unsigned NSYNC = 9;

    function automatic logic [1:0] word_addr(input logic [23:0] w);
        return w[SSP_ADDR_MSB:SSP_ADDR_LSB];
    endfunction : word_addr

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic             s_clk;
    logic             s_le;
    logic             s_data;
    logic             s_pon;
    logic             s_ref;
    logic [1:0]       s_pd_act;
    logic             clk_d;
    logic             le_d;
    logic             ref_d;
    logic             clk_rise;
    logic             le_rise;
    logic             le_fall;
    logic             ref_rise;

    assign raw_in = {aux_pd_dn_i, aux_pd_up_i, main_pd_dn_i, main_pd_up_i,
                     ref_in_i, link.hard_power_pin, link.serial_data,
                     link.latch_enable, link.serial_clk};

    ssp_sync #(
        .WIDTH (NSYNC)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (raw_in),
        .sync_o    (syn)
    );

    assign s_clk       = syn[0];
    assign s_le        = syn[1];
    assign s_data      = syn[2];
    assign s_pon       = syn[3];
    assign s_ref       = syn[4];
    assign s_pd_act[0] = syn[5] | syn[6];
    assign s_pd_act[1] = syn[7] | syn[8];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            clk_d <= 1'b0;
            le_d  <= 1'b0;
            ref_d <= 1'b0;
        end else begin
            clk_d <= s_clk;
            le_d  <= s_le;
            ref_d <= s_ref;
        end
    end

    assign clk_rise = s_clk & ~clk_d;
    assign le_rise  = s_le & ~le_d;
    assign le_fall  = ~s_le & le_d;
    assign ref_rise = s_ref & ~ref_d;

    // serial shift register, p0 first ends in bit 0
    logic [23:0] shift_reg;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            shift_reg <= '0;
        end else if (clk_rise && !s_le) begin
            shift_reg <= {s_data, shift_reg[23:1]};
        end
    end

    logic load_div;
    logic load_ref;
    logic load_cfg;
    logic load_tst;

    // word lands on latch rise, steered by its address
    always_comb begin
        load_div = 1'b0;
        load_ref = 1'b0;
        load_cfg = 1'b0;
        load_tst = 1'b0;
        if (le_rise) begin
            if (word_addr(shift_reg) == SSP_ADDR_DIV) begin
                load_div = 1'b1;
            end else if (word_addr(shift_reg) == SSP_ADDR_REF) begin
                load_ref = 1'b1;
            end else if (word_addr(shift_reg) == SSP_ADDR_CFG) begin
                load_cfg = 1'b1;
            end else begin
                load_tst = 1'b1;
            end
        end
    end

    // reference word and temporary DAC store
    logic       soft_power_bit;
    logic [7:0] comp_dac_temp;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ref_divide_ratio_o  <= SSP_R_RST;
            lock_output_mode_o  <= SSP_LO_RST;
            soft_power_bit      <= SSP_PD_RST;
            pump_ratio_select_o <= SSP_CP_RST;
            comp_dac_temp       <= SSP_FC_RST;
        end else if (load_ref) begin
            ref_divide_ratio_o  <= shift_reg[SSP_R_MSB:SSP_R_LSB];
            lock_output_mode_o  <= shift_reg[SSP_LO_POS];
            soft_power_bit      <= shift_reg[SSP_PD_POS];
            pump_ratio_select_o <= shift_reg[SSP_CP_POS];
            comp_dac_temp       <= shift_reg[SSP_FC_MSB:SSP_FC_LSB];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            config_word_o <= '0;
        end else if (load_cfg) begin
            config_word_o <= shift_reg[21:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            test_bits_o <= '0;
        end else if (load_tst) begin
            test_bits_o <= shift_reg[21:0];
        end
    end

    // divider word staged, applied at a divider cycle boundary
    logic [15:0] n_stage;
    logic        fm_stage;
    logic [2:0]  nf_stage;
    logic [7:0]  fc_stage;
    logic        reload_pending;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            n_stage  <= SSP_N_RST;
            fm_stage <= SSP_FM_RST;
            nf_stage <= SSP_NF_RST;
            fc_stage <= SSP_FC_RST;
        end else if (load_div) begin
            n_stage  <= shift_reg[SSP_N_MSB:SSP_N_LSB];
            fm_stage <= shift_reg[SSP_FM_POS];
            nf_stage <= shift_reg[SSP_NF_MSB:SSP_NF_LSB];
            fc_stage <= comp_dac_temp;
        end
    end

    // a load in the boundary cycle wins, so it is never dropped
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            reload_pending <= 1'b0;
        end else if (load_div) begin
            reload_pending <= 1'b1;
        end else if (main_cycle_end_i) begin
            reload_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            main_divide_ratio_o       <= SSP_N_RST;
            fraction_modulus_select_o <= SSP_FM_RST;
            fraction_increment_o      <= SSP_NF_RST;
            comp_dac_value_o          <= SSP_FC_RST;
        end else if (reload_pending && main_cycle_end_i) begin
            main_divide_ratio_o       <= n_stage;
            fraction_modulus_select_o <= fm_stage;
            fraction_increment_o      <= nf_stage;
            comp_dac_value_o          <= fc_stage;
        end
    end

    // power state and divider resync
    logic next_power_up;

    assign next_power_up = s_pon ^ soft_power_bit;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            power_up_o     <= 1'b0;
            divider_sync_o <= 1'b0;
        end else begin
            power_up_o     <= next_power_up;
            divider_sync_o <= next_power_up & ~power_up_o;
        end
    end

    // fraction accumulator; increment must stay below the modulus
    logic [3:0] acc_sum;
    logic [3:0] acc_mod;

    assign acc_sum = {1'b0, fraction_acc_o} + {1'b0, fraction_increment_o};
    assign acc_mod = fraction_modulus_select_o ? SSP_MOD_5 : SSP_MOD_8;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            fraction_acc_o   <= '0;
            fraction_carry_o <= 1'b0;
        end else if (divider_sync_o) begin
            fraction_acc_o   <= '0;
            fraction_carry_o <= 1'b0;
        end else if (main_cycle_end_i) begin
            if (acc_sum >= acc_mod) begin
                fraction_acc_o   <= 3'(acc_sum - acc_mod);
                fraction_carry_o <= 1'b1;
            end else begin
                fraction_acc_o   <= acc_sum[2:0];
                fraction_carry_o <= 1'b0;
            end
        end else begin
            fraction_carry_o <= 1'b0;
        end
    end

    // speed-up window from divider word latch to latch fall
    logic div_speedup;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            div_speedup <= 1'b0;
        end else if (load_div) begin
            div_speedup <= 1'b1;
        end else if (le_fall) begin
            div_speedup <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            speedup_o           <= 1'b0;
            pump_current_mult_o <= SSP_PUMP_CP0_NORM;
        end else begin
            speedup_o <= div_speedup | test_bits_o[SSP_TSPU_POS];
            if (pump_ratio_select_o) begin
                pump_current_mult_o <= (div_speedup | test_bits_o[SSP_TSPU_POS])
                    ? SSP_PUMP_CP1_SU : SSP_PUMP_CP1_NORM;
            end else begin
                pump_current_mult_o <= (div_speedup | test_bits_o[SSP_TSPU_POS])
                    ? SSP_PUMP_CP0_SU : SSP_PUMP_CP0_NORM;
            end
        end
    end

    // lock judge: a detector pulse spanning a whole reference period
    // means phase error of at least one period
    logic [1:0] held;
    logic [1:0] loop_locked;
    logic [1:0] counter_on;

    assign counter_on = {aux_power_on_i, power_up_o};

    for (genvar g = 0; g < 2; g++) begin : g_lock
        always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
                held[g]        <= 1'b0;
                loop_locked[g] <= 1'b0;
            end else if (!counter_on[g]) begin
                held[g]        <= 1'b0;
                loop_locked[g] <= 1'b0;
            end else if (ref_rise) begin
                loop_locked[g] <= ~held[g];
                held[g]        <= s_pd_act[g];
            end else begin
                held[g]        <= held[g] & s_pd_act[g];
            end
        end
    end

    logic settled;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            settled <= 1'b0;
        end else begin
            settled <= (|counter_on)
                & (loop_locked[0] | ~counter_on[0])
                & (loop_locked[1] | ~counter_on[1]);
        end
    end

    assign link.phase_settled = settled;
endmodule : ssp_device

//--- ssp_host.sv
// host side: APB registers driving the three-wire programming link
module ssp_host
    import ssp_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    ssp_link_if.host         link
);
    ssp_host_state_type state;
    logic [23:0]        tx_word;
    logic [4:0]         bit_cnt;
    logic [7:0]         tick_cnt;
    logic               hard_power;
    logic               settled_sync;
    logic               setup_ph;
    logic               access_ph;
    logic               busy;
    logic               tx_write;

    ssp_sync #(
        .WIDTH (1)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (link.phase_settled),
        .sync_o    (settled_sync)
    );

    assign setup_ph  = psel_i & ~penable_i;
    assign access_ph = psel_i & penable_i;
    assign busy      = (state != SSP_H_IDLE);
    assign pready_o  = 1'b1;
    assign tx_write  = access_ph & pwrite_i & (paddr_i == SSP_REG_TX) & ~busy;

    // unmapped address, TX read, STATUS write, or a word written while a frame is running
    always_comb begin
        pslverr_o = 1'b0;
        if (access_ph) begin
            if (paddr_i == SSP_REG_TX) begin
                pslverr_o = ~pwrite_i | busy;
            end else if (paddr_i == SSP_REG_CTRL) begin
                pslverr_o = 1'b0;
            end else if (paddr_i == SSP_REG_STATUS) begin
                pslverr_o = pwrite_i;
            end else begin
                pslverr_o = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            prdata_o <= '0;
        end else if (setup_ph && !pwrite_i) begin
            if (paddr_i == SSP_REG_CTRL) begin
                prdata_o <= {31'h0, hard_power};
            end else if (paddr_i == SSP_REG_STATUS) begin
                prdata_o <= {30'h0, settled_sync, busy};
            end else begin
                prdata_o <= '0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hard_power <= SSP_CTRL_RST;
        end else if (access_ph && pwrite_i && paddr_i == SSP_REG_CTRL) begin
            hard_power <= pwdata_i[0];
        end
    end

    // serial engine: data set with clock low, device samples on rise
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state             <= SSP_H_IDLE;
            tx_word           <= '0;
            bit_cnt           <= '0;
            tick_cnt          <= '0;
            link.serial_clk   <= 1'b0;
            link.latch_enable <= 1'b0;
            link.serial_data  <= 1'b0;
        end else begin
            case (state)
                SSP_H_IDLE: begin
                    if (tx_write) begin
                        tx_word          <= pwdata_i[23:0];
                        bit_cnt          <= '0;
                        tick_cnt         <= '0;
                        link.serial_data <= pwdata_i[0];
                        state            <= SSP_H_LOW;
                    end
                end
                SSP_H_LOW: begin
                    if (tick_cnt == 8'(SSP_HALF_CYC - 1)) begin
                        tick_cnt        <= '0;
                        link.serial_clk <= 1'b1;
                        state           <= SSP_H_HIGH;
                    end else begin
                        tick_cnt <= tick_cnt + 8'h01;
                    end
                end
                SSP_H_HIGH: begin
                    if (tick_cnt == 8'(SSP_HALF_CYC - 1)) begin
                        tick_cnt        <= '0;
                        link.serial_clk <= 1'b0;
                        if (bit_cnt == 5'(SSP_WORD_BITS - 1)) begin
                            link.latch_enable <= 1'b1;
                            state             <= SSP_H_LATCH;
                        end else begin
                            bit_cnt          <= bit_cnt + 5'h01;
                            tx_word          <= {1'b0, tx_word[23:1]};
                            link.serial_data <= tx_word[1];
                            state            <= SSP_H_LOW;
                        end
                    end else begin
                        tick_cnt <= tick_cnt + 8'h01;
                    end
                end
                SSP_H_LATCH: begin
                    if (tick_cnt == 8'(SSP_LATCH_CYC - 1)) begin
                        tick_cnt          <= '0;
                        link.latch_enable <= 1'b0;
                        state             <= SSP_H_IDLE;
                    end else begin
                        tick_cnt <= tick_cnt + 8'h01;
                    end
                end
                default: begin
                    state <= SSP_H_IDLE;
                end
            endcase
        end
    end

    assign link.hard_power_pin = hard_power;
endmodule : ssp_host

//--- ssp_link_if.sv
// three-wire programming link plus power pin and settled output
interface ssp_link_if;
    logic serial_clk;
    logic latch_enable;
    logic serial_data;
    logic hard_power_pin;
    logic phase_settled;

    modport host (
        output serial_clk,
        output latch_enable,
        output serial_data,
        output hard_power_pin,
        input  phase_settled
    );
    modport device (
        input  serial_clk,
        input  latch_enable,
        input  serial_data,
        input  hard_power_pin,
        output phase_settled
    );
endinterface : ssp_link_if

//--- ssp_pkg.sv
// constants shared by both ends of the serial programming link
package ssp_pkg;
    localparam int unsigned SSP_WORD_BITS = 24;
    localparam int unsigned SSP_CLK_MHZ   = 200;

    // address field p23..p22
    localparam int unsigned SSP_ADDR_MSB = 23;
    localparam int unsigned SSP_ADDR_LSB = 22;
    localparam logic [1:0]  SSP_ADDR_DIV = 2'h0;
    localparam logic [1:0]  SSP_ADDR_REF = 2'h1;
    localparam logic [1:0]  SSP_ADDR_CFG = 2'h2;
    localparam logic [1:0]  SSP_ADDR_TST = 2'h3;

    // divider word fields
    localparam int unsigned SSP_FM_POS    = 21;
    localparam int unsigned SSP_NF_MSB    = 20;
    localparam int unsigned SSP_NF_LSB    = 18;
    localparam int unsigned SSP_N_MSB     = 17;
    localparam int unsigned SSP_N_LSB     = 2;
    localparam logic        SSP_FM_RST    = 1'h0;
    localparam logic [2:0]  SSP_NF_RST    = 3'h2;
    localparam logic [15:0] SSP_N_RST     = 16'h4460;

    // reference word fields
    localparam int unsigned SSP_R_MSB     = 21;
    localparam int unsigned SSP_R_LSB     = 12;
    localparam int unsigned SSP_LO_POS    = 11;
    localparam int unsigned SSP_PD_POS    = 10;
    localparam int unsigned SSP_CP_POS    = 9;
    localparam int unsigned SSP_FC_MSB    = 8;
    localparam int unsigned SSP_FC_LSB    = 1;
    localparam logic [9:0]  SSP_R_RST     = 10'h051;
    localparam logic        SSP_LO_RST    = 1'h0;
    localparam logic        SSP_PD_RST    = 1'h0;
    localparam logic        SSP_CP_RST    = 1'h0;
    localparam logic [7:0]  SSP_FC_RST    = 8'h50;

    // test word speed-up bit
    localparam int unsigned SSP_TSPU_POS  = 14;

    // pump multiples of the bias current
    localparam logic [3:0]  SSP_PUMP_CP0_NORM = 4'h3;
    localparam logic [3:0]  SSP_PUMP_CP0_SU   = 4'hf;
    localparam logic [3:0]  SSP_PUMP_CP1_NORM = 4'h1;
    localparam logic [3:0]  SSP_PUMP_CP1_SU   = 4'h5;

    localparam logic [3:0]  SSP_MOD_8 = 4'h8;
    localparam logic [3:0]  SSP_MOD_5 = 4'h5;

    // serial bus timing
    localparam int unsigned SSP_TCY_NS    = 100;
    localparam int unsigned SSP_TCY_CYC   =
        (SSP_TCY_NS * SSP_CLK_MHZ + 999) / 1000;
    localparam int unsigned SSP_HALF_CYC  = (SSP_TCY_CYC + 1) / 2;
    localparam int unsigned SSP_LATCH_CYC = SSP_TCY_CYC;

    // host register map
    localparam logic [7:0]  SSP_REG_TX     = 8'h00;
    localparam logic [7:0]  SSP_REG_CTRL   = 8'h04;
    localparam logic [7:0]  SSP_REG_STATUS = 8'h08;
    localparam logic        SSP_CTRL_RST   = 1'h0;

    typedef enum logic [1:0] {
        SSP_H_IDLE,
        SSP_H_LOW,
        SSP_H_HIGH,
        SSP_H_LATCH
    } ssp_host_state_type;
endpackage : ssp_pkg

//--- ssp_props.sv
// link-level assertions on the programming wires
module ssp_props (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic serial_clk,
    input wire logic latch_enable,
    input wire logic serial_data,
    input wire logic hard_power_pin,
    input wire logic phase_settled
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] bits;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // cleared while latched so the count still stands at the latch rise
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || latch_enable)
            bits <= 5'h00;
        else if ($rose(serial_clk))
            bits <= bits + 5'h01;
    end
    a_latch_no_clk: assert property (latch_enable |-> !serial_clk)
        else $error("serial clock high while latched");
    a_word_bits: assert property ($rose(latch_enable) |-> bits == 5'h18)
        else $error("word length not 24 bits");
    a_data_hold: assert property (serial_clk |-> $stable(serial_data))
        else $error("data moved while clock high");
    a_clk_high: assert property ($rose(serial_clk) |-> serial_clk[*8])
        else $error("clock high phase too short");
    a_clk_low: assert property ($fell(serial_clk) |-> !serial_clk[*8])
        else $error("clock low phase too short");
    a_clk_fall: assert property ($rose(serial_clk) |-> ##[8:12] !serial_clk)
        else $error("clock high phase too long");
    a_latch_width: assert property ($rose(latch_enable) |->
        latch_enable[*8] ##[10:14] !latch_enable)
        else $error("latch pulse width wrong");
    a_latch_follows: assert property ($fell(serial_clk) && bits == 5'h18
        |-> ##[1:40] latch_enable)
        else $error("no latch after full word");
    cover property ($rose(latch_enable));
    cover property ($rose(phase_settled));
    cover property ($fell(hard_power_pin));
endmodule : ssp_props

//--- ssp_sync.sv
// two-flop synchroniser bank for foreign-domain inputs
module ssp_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) $error("ssp_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end
endmodule : ssp_sync
